// *** bench/tb_tmp_prog.sv ***
// Self-checking bench for the programming block
`timescale 1ns/1ps
module tb_tmp_prog;
   logic        CLK                  = 1'b0;
   logic        RESET_N              = 1'b0;
   logic        TAP_PORT_ENABLE_FUSE = 1'b1;
   logic        TAP_DISABLE_SET      = 1'b0;
   logic        EXT_RESET_N          = 1'b1;
   logic [14:0] CMD_RESULT           = 15'h0000;
   logic [15:0] MEM_RDATA            = 16'h0000;
   wire         TCK, TMS, TDI, TDO, TDO_OE_N, TAP_DISABLE_BIT, CORE_RESET;
   wire         PROG_MODE, CMD_STROBE, CMD_EXEC, PBUF_HIGH, PBUF_WE;
   wire  [14:0] CMD_OUT;
   wire  [15:0] MEM_ADDR;
   wire  [7:0]  PBUF_DATA;
   int          n_fail = 0, n_checks = 0, n_strobe = 0, n_exec = 0, n_oe = 0, s0;
   logic [24:0] we_q[$];
   logic [15:0] d, a, w;
   logic [7:0]  pb[4];

   tmp_prog u_dut (.CLK, .RESET_N, .TCK, .TMS, .TDI, .TDO, .TDO_OE_N,
      .TAP_PORT_ENABLE_FUSE, .TAP_DISABLE_SET, .EXT_RESET_N, .TAP_DISABLE_BIT,
      .CORE_RESET, .PROG_MODE, .CMD_OUT, .CMD_STROBE, .CMD_EXEC, .CMD_RESULT,
      .MEM_ADDR, .PBUF_DATA, .PBUF_HIGH, .PBUF_WE, .MEM_RDATA);
   tmp_prog_host u_host (.CLK, .TCK, .TMS, .TDI, .TDO);

   always #2.5 CLK = ~CLK;

   function automatic logic [15:0] word_at(logic [15:0] base, int i);
      return 16'(base + i / 2);
   endfunction

   function automatic logic [15:0] rd_fn(logic [15:0] ad);
      return ad ^ 16'h5a3c;
   endfunction

   // Program memory and event counters
   always @(posedge CLK)
   begin
      MEM_RDATA <= rd_fn(MEM_ADDR);
      if (CMD_STROBE === 1'b1)
         n_strobe++;
      if (CMD_EXEC === 1'b1)
         n_exec++;
      if (PBUF_WE === 1'b1)
         we_q.push_back({MEM_ADDR, PBUF_HIGH, PBUF_DATA});
      if (TDO_OE_N === 1'b0)
         n_oe++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_checks++;
         if (got !== exp)
         begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask

   task automatic finish_test();
      begin
         $display("Checks %0d, mismatches %0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   task automatic do_cmd(input logic [14:0] c);
      logic [14:0] r;
      int          e;
      int          o;
      begin
         r = 15'($urandom);
         e = n_exec;
         o = n_oe;
         @(posedge CLK);
         CMD_RESULT <= r;
         u_host.scan(1'b0, 15, {1'b0, c}, d);
         chk(d[14:0], r);
         chk(n_oe - o, 16 * 15);
         chk(TDO_OE_N, 1'b1);
         chk(CMD_OUT, c);
         chk(n_exec, e + 1);
      end
   endtask

   task automatic set_addr(input logic [15:0] ad);
      begin
         u_host.scan(1'b1, 4, 16'h5, d);
         do_cmd({7'h07, ad[15:8]});
         do_cmd({7'h03, ad[7:0]});
         chk(MEM_ADDR, ad);
      end
   endtask

   task automatic unlock();
      begin
         u_host.scan(1'b1, 4, 16'h4, d);
         u_host.scan(1'b0, 16, 16'ha371, d);
         chk(PROG_MODE, 1'b0);
         u_host.scan(1'b0, 16, 16'ha370, d);
         chk(PROG_MODE, 1'b1);
      end
   endtask

   initial
   begin
      #400us;
      n_fail++;
      finish_test();
   end

   initial
   begin
      void'($urandom(32'hbba1));
      repeat (5) @(posedge CLK);
      RESET_N <= 1'b1;
      repeat (4) @(posedge CLK);
      u_host.reset_tap();
      u_host.scan(1'b1, 4, 16'hc, d);
      chk(d[3:0], 4'h1);
      u_host.scan(1'b0, 1, 16'h1, d);
      chk(CORE_RESET, 1'b1);
      u_host.scan(1'b0, 1, 16'h0, d);
      chk(d[0], 1'b1);
      repeat (70) @(posedge CLK);
      chk(CORE_RESET, 1'b0);
      u_host.scan(1'b1, 4, 16'h5, d);
      u_host.scan(1'b0, 15, 16'h0703, d);
      u_host.scan(1'b1, 4, 16'h6, d);
      u_host.scan(1'b0, 8, 16'h5a, d);
      chk(n_strobe + we_q.size(), 0);
      unlock();
      // Page load across a low-byte carry
      a = {8'($urandom), 8'hff};
      set_addr(a);
      u_host.scan(1'b1, 4, 16'h6, d);
      for (int i = 0; i < 4; i++)
      begin
         pb[i] = 8'($urandom);
         u_host.scan(1'b0, 8, {8'h00, pb[i]}, d);
      end
      chk(we_q.size(), 4);
      for (int i = 0; i < 4; i++)
         chk(we_q[i], {word_at(a, i), 1'(i % 2), pb[i]});
      chk(MEM_ADDR, word_at(a, 2));
      // Page read
      a = 16'($urandom);
      set_addr(a);
      u_host.scan(1'b1, 4, 16'h7, d);
      for (int i = 0; i < 4; i++)
      begin
         w = rd_fn(word_at(a, i));
         u_host.scan(1'b0, 8, 16'h0000, d);
         chk(d[7:0], (i % 2) ? w[15:8] : w[7:0]);
      end
      chk(MEM_ADDR, word_at(a, 4));
      // Fuse low, then disable bit set
      for (int k = 0; k < 2; k++)
      begin
         @(posedge CLK);
         TAP_PORT_ENABLE_FUSE <= (k == 1);
         TAP_DISABLE_SET <= (k == 1);
         @(posedge CLK);
         TAP_DISABLE_SET <= 1'b0;
         s0 = n_strobe;
         u_host.scan(1'b1, 4, 16'h5, d);
         u_host.scan(1'b0, 15, 16'h0300, d);
         chk(n_strobe, s0);
         chk(TAP_DISABLE_BIT, k);
      end
      EXT_RESET_N <= 1'b0;
      repeat (10) @(posedge CLK);
      chk(TAP_DISABLE_BIT, 1'b0);
      EXT_RESET_N <= 1'b1;
      repeat (4) @(posedge CLK);
      u_host.reset_tap();
      unlock();
      set_addr(16'($urandom));
      // Unused code falls back to one-bit bypass
      u_host.scan(1'b1, 4, 16'h2, d);
      w = 16'($urandom);
      u_host.scan(1'b0, 16, w, d);
      chk(d, {w[14:0], 1'b0});
      finish_test();
   end
endmodule // tb_tmp_prog

// *** bench/tmp_prog_host.sv ***
// Programmer model driving three test-port pins and reading TDO
`timescale 1ns/1ps
module tmp_prog_host (
   input  wire  CLK,
   output logic TCK = 1'b0,
   output logic TMS = 1'b1,
   output logic TDI = 1'b0,
   input  wire  TDO
);
   // 8 CLK half period, far below max
   task automatic step(input logic ms, input logic di, output logic bit_o);
      begin
         @(posedge CLK);
         TCK <= 1'b0;
         TMS <= ms;
         TDI <= di;
         repeat (8) @(posedge CLK);
         bit_o = TDO;
         TCK <= 1'b1;
         repeat (7) @(posedge CLK);
      end
   endtask

   // Clock stands low, released data toggles
   task automatic park();
      begin
         @(posedge CLK);
         TCK <= 1'b0;
         TDI <= ~TDI;
      end
   endtask

   // pins only, no reset pin, no scan use
   task automatic reset_tap();
      logic b;
      begin
         repeat (5) step(1'b1, 1'b0, b);
         step(1'b0, 1'b0, b);
         park();
      end
   endtask

   // LSB first in and out, ends with idle clock
   task automatic scan(input logic ir, input int n, input logic [15:0] din,
                       output logic [15:0] dout);
      logic b;
      begin
         dout = 16'h0000;
         step(1'b1, 1'b0, b);
         if (ir)
            step(1'b1, 1'b0, b);
         step(1'b0, 1'b0, b);
         step(1'b0, 1'b0, b);
         for (int i = 0; i < n; i++)
         begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
         end
         step(1'b1, 1'b0, b);
         step(1'b0, 1'b0, b);
         step(1'b0, 1'b0, b);
         park();
      end
   endtask
endmodule // tmp_prog_host

// *** bench/tmp_prog_monitor.sv ***
// Concurrent checks on the ports of the programming block
`timescale 1ns/1ps
module tmp_prog_monitor (
   input wire        CLK,
   input wire        RESET_N,
   input wire        TAP_PORT_ENABLE_FUSE,
   input wire        TAP_DISABLE_SET,
   input wire        EXT_RESET_N,
   input wire        TAP_DISABLE_BIT,
   input wire        CORE_RESET,
   input wire        PROG_MODE,
   input wire [14:0] CMD_OUT,
   input wire        CMD_STROBE,
   input wire        CMD_EXEC,
   input wire [15:0] MEM_ADDR,
   input wire        PBUF_HIGH,
   input wire        PBUF_WE
);
   default clocking mon_cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   logic [7:0]  hi_cnt_q;
   logic [15:0] lo_addr_q;

   // Cycles spent in core reset
   always @(posedge CLK)
   begin
      if (!RESET_N || !CORE_RESET)
         hi_cnt_q <= 8'h00;
      else if (hi_cnt_q != 8'hff)
         hi_cnt_q <= hi_cnt_q + 8'h01;
   end

   // Word of the last low byte
   always @(posedge CLK)
   begin
      if (!RESET_N)
         lo_addr_q <= 16'h0000;
      else if (PBUF_WE && !PBUF_HIGH)
         lo_addr_q <= MEM_ADDR;
   end

   sequence s_ext_hold;
      (!EXT_RESET_N && !TAP_DISABLE_SET) [*6];
   endsequence

   sequence s_port_dead;
      (!TAP_PORT_ENABLE_FUSE || TAP_DISABLE_BIT) [*2];
   endsequence

   AST_STROBE_ONE: assert property (CMD_STROBE |-> PROG_MODE ##1 !CMD_STROBE)
      else $error("command strobe bad");
   AST_CMD_HOLD: assert property ($changed(CMD_OUT) |-> CMD_STROBE)
      else $error("command changed without strobe");
   AST_EXEC_ONE: assert property (CMD_EXEC |-> PROG_MODE ##1 !CMD_EXEC)
      else $error("execute pulse bad");
   AST_EXEC_GAP: assert property (CMD_STROBE |=> (!CMD_EXEC) [*6])
      else $error("execute before idle visit");
   AST_WE_ONE: assert property (PBUF_WE |-> PROG_MODE ##1 !PBUF_WE)
      else $error("page write pulse bad");
   AST_HIGH_SAME_WORD: assert property (PBUF_WE && PBUF_HIGH |-> MEM_ADDR == lo_addr_q)
      else $error("high byte not at low byte word");
   AST_DIS_CLEAR: assert property (s_ext_hold |-> !TAP_DISABLE_BIT)
      else $error("disable bit not cleared");
   AST_PORT_DEAD: assert property (s_port_dead |-> !CMD_STROBE && !PBUF_WE && !CMD_EXEC)
      else $error("activity while port disabled");
   AST_RST_TIMEOUT: assert property ($fell(CORE_RESET) |-> hi_cnt_q >= 8'h40)
      else $error("core reset time-out too short");
endmodule // tmp_prog_monitor

bind tmp_prog tmp_prog_monitor u_mon (
   .CLK,
   .RESET_N,
   .TAP_PORT_ENABLE_FUSE,
   .TAP_DISABLE_SET,
   .EXT_RESET_N,
   .TAP_DISABLE_BIT,
   .CORE_RESET,
   .PROG_MODE,
   .CMD_OUT,
   .CMD_STROBE,
   .CMD_EXEC,
   .MEM_ADDR,
   .PBUF_HIGH,
   .PBUF_WE
);

// *** rtl/tmp_fifo.v ***
// Small valid/ready FIFO for page-load words
`timescale 1ns/1ps
module tmp_fifo #(
   parameter WIDTH = 24,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk,
   input  wire             reset_n,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output reg              out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_q;
   reg [AW:0]      rd_q;
   wire            empty;
   wire            full;
   wire            pop;
   wire            push;
   assign empty    = (wr_q == rd_q);
   assign full     = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready = ~full;
   assign push     = in_valid & ~full;
   assign pop      = ~empty & (~out_valid | out_ready);
   always @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         wr_q      <= {(AW+1){1'b0}};
         rd_q      <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data  <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q      <= rd_q + 1'b1;
            out_data  <= mem[rd_q[AW-1:0]];
            out_valid <= 1'b1;
         end
         else if (out_ready)
         begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule // tmp_fifo

// *** rtl/tmp_map.vh ***
// Constants for the test-port memory programming block
`ifndef TMP_MAP_VH
`define TMP_MAP_VH
`define TMP_IR_W        4
`define TMP_IR_RESET    4'hc
`define TMP_IR_UNLOCK   4'h4
`define TMP_IR_CMD      4'h5
`define TMP_IR_PLOAD    4'h6
`define TMP_IR_PREAD    4'h7
`define TMP_IR_BYPASS   4'hf
`define TMP_IR_CAPTURE  4'h1
`define TMP_UNLOCK_W    16
`define TMP_SIGNATURE   16'ha370
`define TMP_CMD_W       15
`define TMP_BYTE_W      8
`define TMP_ADDR_W      16
`define TMP_ADDR_ONE    16'h0001
`define TMP_CMD_ADDR_HI 7'h07
`define TMP_CMD_ADDR_LO 7'h03
`define TMP_FIFO_DEPTH  8
`define TMP_FIFO_AW     3
`define TMP_DIS_CLR_CYC 2'h2
`define TMP_PLOAD_MAX_TCK 11
`define TMP_RST_TOUT_CYC 8'h40
`endif

// *** rtl/tmp_prog.v ***
// Test-port memory programming block: TAP, data registers, page load/read
`timescale 1ns/1ps
`include "tmp_map.vh"
module tmp_prog (
   input  wire        CLK,
   input  wire        RESET_N,
   input  wire        TCK,
   input  wire        TMS,
   input  wire        TDI,
   output reg         TDO,
   output reg         TDO_OE_N,
   input  wire        TAP_PORT_ENABLE_FUSE,
   input  wire        TAP_DISABLE_SET,
   input  wire        EXT_RESET_N,
   output reg         TAP_DISABLE_BIT,
   output reg         CORE_RESET,
   output reg         PROG_MODE,
   output reg  [14:0] CMD_OUT,
   output reg         CMD_STROBE,
   output reg         CMD_EXEC,
   input  wire [14:0] CMD_RESULT,
   output reg  [15:0] MEM_ADDR,
   output reg  [7:0]  PBUF_DATA,
   output reg         PBUF_HIGH,
   output reg         PBUF_WE,
   input  wire [15:0] MEM_RDATA
);
   localparam S_TLR = 16'h0001;
   localparam S_RTI = 16'h0002;
   localparam S_CDR = 16'h0008;
   localparam S_SHD = 16'h0010;
   localparam S_UDR = 16'h0100;
   localparam S_CIR = 16'h0400;
   localparam S_SHI = 16'h0800;
   localparam S_UIR = 16'h8000;

   reg  [2:0]  tck_s_q;
   reg  [1:0]  tms_s_q;
   reg  [1:0]  tdi_s_q;
   reg  [1:0]  ext_s_q;
   wire        tck_rise;
   wire        tck_fall;
   wire [15:0] tap_state;
   reg  [`TMP_IR_W-1:0]     ir_sh_q;
   reg  [`TMP_IR_W-1:0]     ir_q;
   reg                      rst_chain_q;
   reg  [`TMP_UNLOCK_W-1:0] unlock_q;
   reg  [`TMP_CMD_W-1:0]    cmd_sh_q;
   reg                      bypass_q;
   reg                      ld_high_q;
   reg                      ld_first_q;
   reg                      rd_high_q;
   reg                      rd_inc_q;
   reg  [1:0]               dis_cnt_q;
   reg  [7:0]               rto_cnt_q;
   reg                      exec_pend_q;
   reg  [`TMP_ADDR_W-1:0]   addr_q;
   wire                     port_on;
   wire                     in_tlr;
   wire                     sel_rst;
   wire                     sel_unl;
   wire                     sel_cmd;
   wire                     sel_pld;
   wire                     sel_prd;
   wire                     dr_out;
   wire [24:0]              fifo_in;
   wire                     fifo_in_ready;
   wire [24:0]              fifo_out;
   wire                     fifo_out_valid;
   wire                     fifo_push;
   wire [`TMP_ADDR_W-1:0]   ld_addr;
   reg                      pbuf_busy_q;

   // Pin inputs synchronised before use
   always @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         tck_s_q <= 3'h0;
         tms_s_q <= 2'h0;
         tdi_s_q <= 2'h0;
         ext_s_q <= 2'h3;
      end
      else
      begin
         tck_s_q <= {tck_s_q[1:0], TCK};
         tms_s_q <= {tms_s_q[0], TMS};
         tdi_s_q <= {tdi_s_q[0], TDI};
         ext_s_q <= {ext_s_q[0], EXT_RESET_N};
      end
   end
   assign port_on  = TAP_PORT_ENABLE_FUSE & ~TAP_DISABLE_BIT;
   assign tck_rise = port_on & tck_s_q[1] & ~tck_s_q[2];
   assign tck_fall = port_on & ~tck_s_q[1] & tck_s_q[2];

   tmp_tap_fsm u_fsm (
      .clk      (CLK),
      .reset_n  (RESET_N),
      .tck_rise (tck_rise),
      .tms      (tms_s_q[1]),
      .state_q  (tap_state)
   );

   assign in_tlr  = (tap_state == S_TLR);
   assign sel_rst = (ir_q == `TMP_IR_RESET);
   assign sel_unl = (ir_q == `TMP_IR_UNLOCK);
   assign sel_cmd = (ir_q == `TMP_IR_CMD);
   assign sel_pld = (ir_q == `TMP_IR_PLOAD);
   assign sel_prd = (ir_q == `TMP_IR_PREAD);
   // data byte shares the command register low bits
   assign dr_out  = sel_rst ? rst_chain_q :
                    sel_unl ? unlock_q[0] :
                    (sel_cmd | sel_pld | sel_prd) ? cmd_sh_q[0] : bypass_q;

   // disable bit cleared two clocks into external reset
   always @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         TAP_DISABLE_BIT <= 1'b0;
         dis_cnt_q       <= 2'h0;
      end
      else if (TAP_DISABLE_SET)
      begin
         TAP_DISABLE_BIT <= 1'b1;
         dis_cnt_q       <= 2'h0;
      end
      else if (TAP_DISABLE_BIT && !ext_s_q[1])
      begin
         if (dis_cnt_q == `TMP_DIS_CLR_CYC - 2'h1)
         begin
            TAP_DISABLE_BIT <= 1'b0;
         end
         dis_cnt_q <= dis_cnt_q + 2'h1;
      end
      else
      begin
         dis_cnt_q <= 2'h0;
      end
   end

   // instruction register shift and update, LSB first
   always @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         ir_sh_q <= `TMP_IR_BYPASS;
         ir_q    <= `TMP_IR_BYPASS;
      end
      else if (tck_rise)
      begin
         if (in_tlr)
         begin
            ir_q <= `TMP_IR_BYPASS;
         end
         else if (tap_state == S_CIR)
         begin
            ir_sh_q <= `TMP_IR_CAPTURE;
         end
         else if (tap_state == S_SHI)
         begin
            ir_sh_q <= {tdi_s_q[1], ir_sh_q[`TMP_IR_W-1:1]};
         end
         else if (tap_state == S_UIR)
         begin
            ir_q <= ir_sh_q;
         end
      end
   end

   // Data registers
   always @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         rst_chain_q <= 1'b0;
         unlock_q    <= {`TMP_UNLOCK_W{1'b0}};
         cmd_sh_q    <= {`TMP_CMD_W{1'b0}};
         bypass_q    <= 1'b0;
         PROG_MODE   <= 1'b0;
      end
      else if (tck_rise)
      begin
         if (tap_state == S_CDR)
         begin
            bypass_q <= 1'b0;
            if (sel_cmd)
            begin
               cmd_sh_q <= CMD_RESULT;
            end
            else if (sel_prd)
            begin
               cmd_sh_q[7:0] <= rd_high_q ? MEM_RDATA[15:8] : MEM_RDATA[7:0];
            end
         end
         else if (tap_state == S_SHD)
         begin
            if (sel_rst)
            begin
               rst_chain_q <= tdi_s_q[1];
            end
            else if (sel_unl)
            begin
               unlock_q <= {tdi_s_q[1], unlock_q[`TMP_UNLOCK_W-1:1]};
            end
            // shift new command in, result out
            else if (sel_cmd)
            begin
               cmd_sh_q <= {tdi_s_q[1], cmd_sh_q[`TMP_CMD_W-1:1]};
            end
            else if (sel_pld | sel_prd)
            begin
               cmd_sh_q[7:0] <= {tdi_s_q[1], cmd_sh_q[7:1]};
            end
            else
            begin
               bypass_q <= tdi_s_q[1];
            end
         end
         else if (tap_state == S_UDR && sel_unl)
         begin
            PROG_MODE <= (unlock_q == `TMP_SIGNATURE);
         end
      end
   end

   always @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         rto_cnt_q  <= 8'h0;
         CORE_RESET <= 1'b0;
      end
      else if (rst_chain_q)
      begin
         rto_cnt_q  <= `TMP_RST_TOUT_CYC;
         CORE_RESET <= 1'b1;
      end
      else if (rto_cnt_q != 8'h0)
      begin
         rto_cnt_q  <= rto_cnt_q - 8'h1;
         CORE_RESET <= 1'b1;
      end
      else
      begin
         CORE_RESET <= 1'b0;
      end
   end

   // Page load words queued toward page buffer
   assign fifo_push = tck_rise & (tap_state == S_UDR) & sel_pld & PROG_MODE;
   // later low bytes go to next word
   assign ld_addr   = (!ld_high_q && !ld_first_q) ? addr_q + `TMP_ADDR_ONE : addr_q;
   assign fifo_in   = {ld_high_q, ld_addr, cmd_sh_q[7:0]};

   // Command path, address counter and page sequencing
   always @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         CMD_OUT     <= {`TMP_CMD_W{1'b0}};
         CMD_STROBE  <= 1'b0;
         CMD_EXEC    <= 1'b0;
         exec_pend_q <= 1'b0;
         addr_q      <= {`TMP_ADDR_W{1'b0}};
         ld_high_q   <= 1'b0;
         ld_first_q  <= 1'b1;
         rd_high_q   <= 1'b0;
         rd_inc_q    <= 1'b0;
      end
      else
      begin
         CMD_STROBE <= 1'b0;
         CMD_EXEC   <= 1'b0;
         if (tck_rise && tap_state == S_UIR)
         begin
            ld_high_q  <= 1'b0;
            ld_first_q <= 1'b1;
            rd_high_q  <= 1'b0;
         end
         if (tck_rise && tap_state == S_UDR && sel_cmd && PROG_MODE)
         begin
            CMD_OUT     <= cmd_sh_q;
            CMD_STROBE  <= 1'b1;
            exec_pend_q <= 1'b1;
            if (cmd_sh_q[14:8] == `TMP_CMD_ADDR_HI)
            begin
               addr_q[15:8] <= cmd_sh_q[7:0];
            end
            else if (cmd_sh_q[14:8] == `TMP_CMD_ADDR_LO)
            begin
               addr_q[7:0] <= cmd_sh_q[7:0];
            end
         end
         // idle state makes the execute clock
         if (tck_rise && tap_state == S_RTI && exec_pend_q)
         begin
            CMD_EXEC    <= 1'b1;
            exec_pend_q <= 1'b0;
         end
         // pre-increment before low bytes after the first
         if (fifo_push && fifo_in_ready)
         begin
            ld_high_q  <= ~ld_high_q;
            ld_first_q <= 1'b0;
            if (!ld_high_q && !ld_first_q)
            begin
               addr_q <= addr_q + `TMP_ADDR_ONE;
            end
         end
         if (tck_rise && tap_state == S_CDR && sel_prd && PROG_MODE)
         begin
            rd_high_q <= ~rd_high_q;
            rd_inc_q  <= rd_high_q;
         end
         else if (rd_inc_q)
         begin
            rd_inc_q <= 1'b0;
            addr_q   <= addr_q + `TMP_ADDR_ONE;
         end
      end
   end

   // page buffer written from FIFO within a few clocks
   tmp_fifo #(
      .WIDTH (25),
      .DEPTH (`TMP_FIFO_DEPTH),
      .AW    (`TMP_FIFO_AW)
   ) u_fifo (
      .clk       (CLK),
      .reset_n   (RESET_N),
      .in_data   (fifo_in),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (~pbuf_busy_q)
   );

   // Page buffer write port, one write per two clocks
   always @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         PBUF_WE     <= 1'b0;
         PBUF_DATA   <= 8'h0;
         PBUF_HIGH   <= 1'b0;
         pbuf_busy_q <= 1'b0;
      end
      else
      begin
         PBUF_WE     <= fifo_out_valid & ~pbuf_busy_q;
         pbuf_busy_q <= fifo_out_valid & ~pbuf_busy_q;
         if (fifo_out_valid && !pbuf_busy_q)
         begin
            PBUF_DATA <= fifo_out[7:0];
            PBUF_HIGH <= fifo_out[24];
         end
      end
   end

   // Address output every clock, data out on falling test clock
   always @(posedge CLK)
   begin
      if (!RESET_N)
      begin
         MEM_ADDR <= {`TMP_ADDR_W{1'b0}};
         TDO      <= 1'b0;
         TDO_OE_N <= 1'b1;
      end
      else
      begin
         MEM_ADDR <= (fifo_out_valid && !pbuf_busy_q) ? fifo_out[23:8] : addr_q;
         if (tck_fall)
         begin
            TDO      <= (tap_state == S_SHI) ? ir_sh_q[0] : dr_out;
            TDO_OE_N <= ~((tap_state == S_SHI) | (tap_state == S_SHD));
         end
      end
   end
endmodule // tmp_prog

// *** rtl/tmp_tap_fsm.v ***
// Boundary-scan TAP state machine, one-hot, stepped on rising test clock edges
`timescale 1ns/1ps
module tmp_tap_fsm (
   input  wire        clk,
   input  wire        reset_n,
   input  wire        tck_rise,
   input  wire        tms,
   output reg  [15:0] state_q
);
   localparam S_TLR = 16'h0001;
   localparam S_RTI = 16'h0002;
   localparam S_SDR = 16'h0004;
   localparam S_CDR = 16'h0008;
   localparam S_SHD = 16'h0010;
   localparam S_E1D = 16'h0020;
   localparam S_PDR = 16'h0040;
   localparam S_E2D = 16'h0080;
   localparam S_UDR = 16'h0100;
   localparam S_SIR = 16'h0200;
   localparam S_CIR = 16'h0400;
   localparam S_SHI = 16'h0800;
   localparam S_E1I = 16'h1000;
   localparam S_PIR = 16'h2000;
   localparam S_E2I = 16'h4000;
   localparam S_UIR = 16'h8000;
   reg [15:0] state_d;
   always @*
   begin
      case (state_q)
         S_TLR: state_d = tms ? S_TLR : S_RTI;
         S_RTI: state_d = tms ? S_SDR : S_RTI;
         S_SDR: state_d = tms ? S_SIR : S_CDR;
         S_CDR: state_d = tms ? S_E1D : S_SHD;
         S_SHD: state_d = tms ? S_E1D : S_SHD;
         S_E1D: state_d = tms ? S_UDR : S_PDR;
         S_PDR: state_d = tms ? S_E2D : S_PDR;
         S_E2D: state_d = tms ? S_UDR : S_SHD;
         S_UDR: state_d = tms ? S_SDR : S_RTI;
         S_SIR: state_d = tms ? S_TLR : S_CIR;
         S_CIR: state_d = tms ? S_E1I : S_SHI;
         S_SHI: state_d = tms ? S_E1I : S_SHI;
         S_E1I: state_d = tms ? S_UIR : S_PIR;
         S_PIR: state_d = tms ? S_E2I : S_PIR;
         S_E2I: state_d = tms ? S_UIR : S_SHI;
         S_UIR: state_d = tms ? S_SDR : S_RTI;
         default: state_d = S_TLR;
      endcase
   end
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_q <= S_TLR;
      end
      else if (tck_rise)
      begin
         state_q <= state_d;
      end
   end
endmodule // tmp_tap_fsm
